// file: pkg/rpdg_cfg.svh
// Constants for the run permit and direction gate: register map, codes, resets.
// Assumes inclusion by bare name from design files and the package.
`ifndef RPDG_CFG_SVH
`define RPDG_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define RPDG_OFS_DIR_LIMIT    8'h00
`define RPDG_OFS_REV_GUARD    8'h04
`define RPDG_OFS_CTRL_METHOD  8'h08
`define RPDG_OFS_FREQ_CEIL    8'h0c
`define RPDG_OFS_FREQ_FLOOR   8'h10
`define RPDG_OFS_STATUS       8'h14
`define RPDG_OFS_IRQ_STAT     8'h18
`define RPDG_OFS_IRQ_MASK     8'h1c
`define RPDG_OFS_TERM_BASE    8'h20
`define RPDG_WORD_SHIFT       2

// ----------------------------------------------------------------------------
// Setting codes
// ----------------------------------------------------------------------------
`define RPDG_DIR_NONE         8'h00
`define RPDG_DIR_FWD_ONLY     8'h01
`define RPDG_DIR_REV_ONLY     8'h02
`define RPDG_GUARD_OFF        8'h00
`define RPDG_GUARD_ON         8'h01
`define RPDG_CM_VF_CT         8'h00
`define RPDG_CM_VF_RT         8'h01
`define RPDG_CM_VF_FREE       8'h02
`define RPDG_CM_VF_ATB        8'h03
`define RPDG_CM_IM_SLV        8'h08
`define RPDG_CM_SM_SLV        8'h0b
`define RPDG_FN_RUN_PERMIT    8'h65
`define RPDG_FN_NONE          8'h00

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RPDG_RST_DIR_LIMIT    8'h00
`define RPDG_RST_REV_GUARD    8'h01
`define RPDG_RST_CTRL_METHOD  8'h00
`define RPDG_RST_FREQ         16'h0000
`define RPDG_RST_IRQ          4'h0

// ----------------------------------------------------------------------------
// Interrupt bit positions
// ----------------------------------------------------------------------------
`define RPDG_IRQ_DIR_BLOCK    0
`define RPDG_IRQ_PERMIT_BLOCK 1
`define RPDG_IRQ_GUARD_CLAMP  2
`define RPDG_IRQ_FREQ_LIMIT   3
`define RPDG_IRQ_W            4

`endif

// file: pkg/rpdg_pkg.sv
// Types shared by the run permit and direction gate.
// Assumes rpdg_cfg.svh is on the include path.
`include "rpdg_cfg.svh"
package rpdg_pkg;

    // ------------------------------------------------------------------------
    // Decoded control method
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        RPDG_MODE_VF_CT,
        RPDG_MODE_VF_RT,
        RPDG_MODE_VF_FREE,
        RPDG_MODE_VF_ATB,
        RPDG_MODE_IM_SLV,
        RPDG_MODE_SM_SLV
    } rpdg_mode_e;

    // ------------------------------------------------------------------------
    // Bus slave states
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        RPDG_BUS_IDLE,
        RPDG_BUS_WRITE,
        RPDG_BUS_RD_WAIT,
        RPDG_BUS_RD_DONE
    } rpdg_bus_e;

endpackage

// file: hw/rpdg_ahb_slave.sv
// AHB-Lite slave front end for the gate registers.
// Assumes single word transfers; register file answers reads combinationally.
`timescale 1ns/1ps
`include "rpdg_cfg.svh"
module rpdg_ahb_slave #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // AHB-Lite
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    // Register file side
    output logic                   reg_wr,
    output logic [ADDR_W-1:0]      reg_addr,
    output logic [31:0]            reg_wdata,
    input  wire logic [31:0]       reg_rdata
);

    if (ADDR_W < 6 || ADDR_W > 32) begin : g_addr_w_chk
        $error("rpdg_ahb_slave: ADDR_W out of range");
    end

    typedef struct packed {
        rpdg_pkg::rpdg_bus_e st;
        logic [ADDR_W-1:0]   addr;
        logic [31:0]         rdata;
    } rpdg_bus_s;

    rpdg_bus_s r;
    rpdg_bus_s nxt;
    logic      take;

    // ------------------------------------------------------------------------
    // Data phase control
    // ------------------------------------------------------------------------
    // Reads take one wait state so hrdata comes from a flop and never sees a
    // write still landing in the same cycle.
    assign hreadyout = (r.st != rpdg_pkg::RPDG_BUS_RD_WAIT);
    assign hresp     = 1'b0;
    assign hrdata    = r.rdata;
    assign reg_wr    = (r.st == rpdg_pkg::RPDG_BUS_WRITE);
    assign reg_addr  = r.addr;
    assign reg_wdata = hwdata;
    assign take      = hsel & htrans[1] & hready;

    always_comb begin
        nxt = r;
        if (r.st == rpdg_pkg::RPDG_BUS_RD_WAIT) begin
            nxt.rdata = reg_rdata;
            nxt.st    = rpdg_pkg::RPDG_BUS_RD_DONE;
        end else if (take) begin
            nxt.addr = haddr[ADDR_W-1:0];
            nxt.st   = hwrite ? rpdg_pkg::RPDG_BUS_WRITE : rpdg_pkg::RPDG_BUS_RD_WAIT;
        end else begin
            nxt.st = rpdg_pkg::RPDG_BUS_IDLE;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    logic unused_ok;
    assign unused_ok = ^{hsize, haddr[31:ADDR_W]};

endmodule

// file: hw/rpdg_gate.sv
// Run permit and direction gate: decides whether a RUN request takes effect.
// Assumes commands synchronous to core_clk; settings written over AHB-Lite.
//
// The implementer's own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "rpdg_cfg.svh"
module rpdg_gate #(
    parameter int FREQ_W = 16,
    parameter int N_TERM = 8
) (
    // Clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    // AHB-Lite
    input  wire logic                     hsel,
    input  wire logic [31:0]              haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              hwdata,
    input  wire logic                     hready,
    output logic                          hreadyout,
    output logic                          hresp,
    output logic [31:0]                   hrdata,
    // Run commands and terminals
    input  wire logic                     run_fwd,
    input  wire logic                     run_rev,
    input  wire logic signed [FREQ_W-1:0] freq_cmd,
    input  wire logic [N_TERM-1:0]        term_in,
    // Control calculation output
    input  wire logic signed [FREQ_W-1:0] ctl_freq,
    // Drive outputs
    output logic                          run_active,
    output logic                          run_dir_rev,
    output logic [FREQ_W-1:0]             freq_ref,
    output logic signed [FREQ_W-1:0]      out_freq,
    output rpdg_pkg::rpdg_mode_e          ctrl_mode,
    output logic                          irq
);

    localparam int ADDR_W = 8;

    if (FREQ_W < 2 || FREQ_W > 16) begin : g_freq_w_chk
        $error("rpdg_gate: FREQ_W must be 2..16");
    end
    if (N_TERM < 1 || N_TERM > 16) begin : g_n_term_chk
        $error("rpdg_gate: N_TERM must be 1..16");
    end

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]                   dir_limit;
        logic [7:0]                   rev_guard;
        logic [7:0]                   ctrl_method;
        logic [N_TERM-1:0][7:0]       term_fn;
        logic [FREQ_W-1:0]            freq_ceil;
        logic [FREQ_W-1:0]            freq_floor;
        logic [`RPDG_IRQ_W-1:0]       irq_stat;
        logic [`RPDG_IRQ_W-1:0]       irq_mask;
        logic [`RPDG_IRQ_W-1:0]       cond_prev;
        logic                         run_active;
        logic                         run_dir_rev;
        logic [FREQ_W-1:0]            freq_ref;
        logic signed [FREQ_W-1:0]     out_freq;
    } rpdg_state_s;

    rpdg_state_s r;
    rpdg_state_s nxt;

    logic              reg_wr;
    logic [ADDR_W-1:0] reg_addr;
    logic [31:0]       reg_wdata;
    logic [31:0]       reg_rdata;

    // ------------------------------------------------------------------------
    // Bus front end
    // ------------------------------------------------------------------------
    rpdg_ahb_slave #(
        .ADDR_W (ADDR_W)
    ) u_bus (
        .core_clk  (core_clk),
        .rst       (rst),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .reg_wr    (reg_wr),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_rdata (reg_rdata)
    );

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic [FREQ_W-1:0] magnitude(input logic signed [FREQ_W-1:0] v);
        magnitude = v[FREQ_W-1] ? FREQ_W'(-v) : FREQ_W'(v);
    endfunction

    function automatic logic [FREQ_W-1:0] clamp(input logic [FREQ_W-1:0] v,
                                                 input logic [FREQ_W-1:0] lo,
                                                 input logic [FREQ_W-1:0] hi);
        if (v > hi) begin
            clamp = hi;
        end else if (v < lo) begin
            clamp = lo;
        end else begin
            clamp = v;
        end
    endfunction

    // True when the address falls on terminal selector slot idx
    function automatic logic is_term(input logic [ADDR_W-1:0] a, input int idx);
        is_term = (a == ADDR_W'(`RPDG_OFS_TERM_BASE + (idx << `RPDG_WORD_SHIFT)));
    endfunction

    // ------------------------------------------------------------------------
    // Method decode
    // ------------------------------------------------------------------------
    rpdg_pkg::rpdg_mode_e mode;
    logic                 mode_known;

    always_comb begin
        mode_known = 1'b1;
        case (r.ctrl_method)
            `RPDG_CM_VF_CT:   mode = rpdg_pkg::RPDG_MODE_VF_CT;
            `RPDG_CM_VF_RT:   mode = rpdg_pkg::RPDG_MODE_VF_RT;
            `RPDG_CM_VF_FREE: mode = rpdg_pkg::RPDG_MODE_VF_FREE;
            `RPDG_CM_VF_ATB:  mode = rpdg_pkg::RPDG_MODE_VF_ATB;
            `RPDG_CM_IM_SLV:  mode = rpdg_pkg::RPDG_MODE_IM_SLV;
            `RPDG_CM_SM_SLV:  mode = rpdg_pkg::RPDG_MODE_SM_SLV;
            default: begin
                // Unknown codes fall back to the safest plain V/f curve
                mode       = rpdg_pkg::RPDG_MODE_VF_CT;
                mode_known = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Run decision
    // ------------------------------------------------------------------------
    logic              req_any;
    logic              req_rev;
    logic              dir_block;
    logic [N_TERM-1:0] permit_sel;
    logic              permit_assigned;
    logic              permit_ok;
    logic              run_ok;
    logic              guard_on;
    logic              guard_clamp;
    logic [FREQ_W-1:0] freq_mag;
    logic              freq_limited;

    always_comb begin
        for (int i = 0; i < N_TERM; i++) begin
            permit_sel[i] = (r.term_fn[i] == `RPDG_FN_RUN_PERMIT);
        end
    end

    // Both run inputs at once is treated as no request
    assign req_any = run_fwd ^ run_rev;
    assign req_rev = run_rev | (run_fwd & freq_cmd[FREQ_W-1]);
    // Limit looks only at the command, never at ctl_freq
    assign dir_block = req_any &
                       (((r.dir_limit == `RPDG_DIR_FWD_ONLY) & req_rev) |
                        ((r.dir_limit == `RPDG_DIR_REV_ONLY) & ~req_rev));
    assign permit_assigned = |permit_sel;
    // Several assigned terminals must all be on
    assign permit_ok = ~permit_assigned | (&(~permit_sel | term_in));
    assign run_ok    = req_any & ~dir_block & permit_ok;
    assign guard_on  = (r.rev_guard == `RPDG_GUARD_ON) &
                       (mode == rpdg_pkg::RPDG_MODE_IM_SLV) & mode_known;
    assign guard_clamp = guard_on & run_ok & (ctl_freq != '0) &
                         (ctl_freq[FREQ_W-1] != req_rev);
    assign freq_mag     = magnitude(freq_cmd);
    assign freq_limited = run_ok & ((freq_mag > r.freq_ceil) | (freq_mag < r.freq_floor));

    // ------------------------------------------------------------------------
    // Register read mux
    // ------------------------------------------------------------------------
    always_comb begin
        reg_rdata = 32'h0000_0000;
        if (reg_addr == `RPDG_OFS_DIR_LIMIT) begin
            reg_rdata[7:0] = r.dir_limit;
        end else if (reg_addr == `RPDG_OFS_REV_GUARD) begin
            reg_rdata[7:0] = r.rev_guard;
        end else if (reg_addr == `RPDG_OFS_CTRL_METHOD) begin
            reg_rdata[7:0] = r.ctrl_method;
        end else if (reg_addr == `RPDG_OFS_FREQ_CEIL) begin
            reg_rdata[FREQ_W-1:0] = r.freq_ceil;
        end else if (reg_addr == `RPDG_OFS_FREQ_FLOOR) begin
            reg_rdata[FREQ_W-1:0] = r.freq_floor;
        end else if (reg_addr == `RPDG_OFS_STATUS) begin
            reg_rdata[7:0] = {mode_known, guard_on, permit_ok, permit_assigned,
                              dir_block, req_rev, r.run_dir_rev, r.run_active};
        end else if (reg_addr == `RPDG_OFS_IRQ_STAT) begin
            reg_rdata[`RPDG_IRQ_W-1:0] = r.irq_stat;
        end else if (reg_addr == `RPDG_OFS_IRQ_MASK) begin
            reg_rdata[`RPDG_IRQ_W-1:0] = r.irq_mask;
        end else begin
            for (int i = 0; i < N_TERM; i++) begin
                if (is_term(reg_addr, i)) begin
                    reg_rdata[7:0] = r.term_fn[i];
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    logic [`RPDG_IRQ_W-1:0] cond;
    logic [`RPDG_IRQ_W-1:0] evt;

    always_comb begin
        nxt = r;
        cond = '0;
        cond[`RPDG_IRQ_DIR_BLOCK]    = dir_block;
        cond[`RPDG_IRQ_PERMIT_BLOCK] = req_any & ~permit_ok;
        cond[`RPDG_IRQ_GUARD_CLAMP]  = guard_clamp;
        cond[`RPDG_IRQ_FREQ_LIMIT]   = freq_limited;
        evt = cond & ~r.cond_prev;
        nxt.cond_prev = cond;

        if (reg_wr) begin
            if (reg_addr == `RPDG_OFS_DIR_LIMIT) begin
                nxt.dir_limit = reg_wdata[7:0];
            end else if (reg_addr == `RPDG_OFS_REV_GUARD) begin
                nxt.rev_guard = reg_wdata[7:0];
            end else if (reg_addr == `RPDG_OFS_CTRL_METHOD) begin
                nxt.ctrl_method = reg_wdata[7:0];
            end else if (reg_addr == `RPDG_OFS_FREQ_CEIL) begin
                nxt.freq_ceil = reg_wdata[FREQ_W-1:0];
            end else if (reg_addr == `RPDG_OFS_FREQ_FLOOR) begin
                nxt.freq_floor = reg_wdata[FREQ_W-1:0];
            end else if (reg_addr == `RPDG_OFS_IRQ_STAT) begin
                nxt.irq_stat = r.irq_stat & ~reg_wdata[`RPDG_IRQ_W-1:0];
            end else if (reg_addr == `RPDG_OFS_IRQ_MASK) begin
                nxt.irq_mask = reg_wdata[`RPDG_IRQ_W-1:0];
            end else begin
                for (int i = 0; i < N_TERM; i++) begin
                    if (is_term(reg_addr, i)) begin
                        nxt.term_fn[i] = reg_wdata[7:0];
                    end
                end
            end
        end
        // Set after clear so a same-cycle event is never lost
        nxt.irq_stat = nxt.irq_stat | evt;

        // Blocked or absent request forces a stopped output
        nxt.run_active  = run_ok;
        nxt.run_dir_rev = run_ok & req_rev;
        if (run_ok) begin
            nxt.freq_ref = clamp(freq_mag, r.freq_floor, r.freq_ceil);
            nxt.out_freq = guard_clamp ? '0 : ctl_freq;
        end else begin
            nxt.freq_ref = '0;
            nxt.out_freq = '0;
        end
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            r             <= '0;
            r.dir_limit   <= `RPDG_RST_DIR_LIMIT;
            r.rev_guard   <= `RPDG_RST_REV_GUARD;
            r.ctrl_method <= `RPDG_RST_CTRL_METHOD;
            r.freq_ceil   <= FREQ_W'(`RPDG_RST_FREQ);
            r.freq_floor  <= FREQ_W'(`RPDG_RST_FREQ);
            r.irq_stat    <= `RPDG_RST_IRQ;
            r.irq_mask    <= `RPDG_RST_IRQ;
        end else begin
            r <= nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign run_active  = r.run_active;
    assign run_dir_rev = r.run_dir_rev;
    assign freq_ref    = r.freq_ref;
    assign out_freq    = r.out_freq;
    assign ctrl_mode   = mode;
    assign irq         = |(r.irq_stat & r.irq_mask);

endmodule

// file: sim/rpdg_gate_chk.sv
// Checker for the run gate: port relations only, one clock domain.
// Assumes the port names of rpdg_gate; bound to every instance below.
`timescale 1ns/1ps
module rpdg_gate_chk #(
    parameter int FREQ_W = 16,
    parameter int N_TERM = 8
) (
    // Clock, reset and bus
    input  wire logic                     core_clk, rst, hsel, hwrite, hready,
    input  wire logic                     hreadyout, hresp,
    input  wire logic [1:0]               htrans,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              haddr, hwdata, hrdata,
    // Run path
    input  wire logic                     run_fwd, run_rev, run_active, run_dir_rev, irq,
    input  wire logic [N_TERM-1:0]        term_in,
    input  wire logic signed [FREQ_W-1:0] freq_cmd, ctl_freq, out_freq,
    input  wire logic [FREQ_W-1:0]        freq_ref,
    input  wire rpdg_pkg::rpdg_mode_e     ctrl_mode
);
    // ----
    // Sequences
    // ----
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence rd_taken; hsel && htrans[1] && hready && !hwrite; endsequence
    sequence wr_taken; hsel && htrans[1] && hready && hwrite; endsequence
    sequence fwd_pos; run_fwd && !run_rev && !freq_cmd[FREQ_W-1]; endsequence
    sequence fwd_neg; run_fwd && !run_rev && freq_cmd[FREQ_W-1]; endsequence

    chk_rd_wait: assert property (rd_taken |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    chk_wr_nowait: assert property (wr_taken |=> hreadyout)
        else $error("write stalled");
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    chk_both_stop: assert property (run_fwd && run_rev |=> !run_active)
        else $error("run with both requests");
    chk_idle_stop: assert property (!run_fwd && !run_rev |=> !run_active)
        else $error("run without request");
    chk_stop_zero: assert property (!run_active |-> freq_ref == '0 && out_freq == '0)
        else $error("output while stopped");
    chk_fwd_dir: assert property (fwd_pos ##1 run_active |-> !run_dir_rev)
        else $error("forward run marked reverse");
    chk_neg_rev: assert property (fwd_neg ##1 run_active |-> run_dir_rev)
        else $error("negative command not reverse");
    chk_guard_off: assert property (run_active && $past(ctrl_mode) !=
        rpdg_pkg::RPDG_MODE_IM_SLV |-> out_freq == $past(ctl_freq))
        else $error("output altered outside vector mode");
endmodule

bind rpdg_gate rpdg_gate_chk #(.FREQ_W(FREQ_W), .N_TERM(N_TERM)) u_chk (
    .core_clk(core_clk), .rst(rst), .hsel(hsel), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .htrans(htrans), .hsize(hsize),
    .haddr(haddr), .hwdata(hwdata), .hrdata(hrdata), .run_fwd(run_fwd),
    .run_rev(run_rev), .run_active(run_active), .run_dir_rev(run_dir_rev),
    .irq(irq), .term_in(term_in), .freq_cmd(freq_cmd), .ctl_freq(ctl_freq),
    .out_freq(out_freq), .freq_ref(freq_ref), .ctrl_mode(ctrl_mode)
);

// file: sim/rpdg_cmd_src.sv
// Model of the terminals and operator that issue RUN commands.
// Assumes the bench sets wanted levels; they reach the pins one edge later.
`timescale 1ns/1ps
module rpdg_cmd_src (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Wanted command
    input  wire logic [1:0]  want_run,
    input  wire logic [15:0] want_freq,
    input  wire logic [15:0] want_ctl,
    input  wire logic [7:0]  want_term,
    // Pins toward the gate
    output logic             run_fwd,
    output logic             run_rev,
    output logic [15:0]      freq_cmd,
    output logic [15:0]      ctl_freq,
    output logic [7:0]       term_in
);
    // Latched like a terminal scan; reset drops every request
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            {run_fwd, run_rev, freq_cmd, ctl_freq, term_in} <= '0;
        end else begin
            {run_fwd, run_rev} <= want_run;
            freq_cmd <= want_freq;
            ctl_freq <= want_ctl;
            term_in <= want_term;
        end
    end
endmodule

// file: sim/tb_run_permit_direction_gate.sv
// Self-checking bench for the run gate, driven over AHB-Lite.
// Assumes the command source model in front of the run inputs.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_run_permit_direction_gate;
    typedef struct packed {
        logic [7:0] d, g, m, f; logic [1:0] c; logic [15:0] fq, cf;
        logic [7:0] tm; logic [1:0] e; logic [15:0] ef, eo;
    } rpdg_row_s;
    logic                 core_clk, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]           htrans = 2'h0, wr = 2'h0;
    logic [31:0]          haddr = '0, hwdata = '0, hrdata, q;
    logic [15:0]          wq = '0, wc = '0, freq_ref, freq_cmd, ctl_freq, out_freq;
    logic [7:0]           wt = '0, term_in;
    logic                 hreadyout, hresp, run_active, run_dir_rev, irq, run_fwd, run_rev;
    rpdg_pkg::rpdg_mode_e ctrl_mode;
    int                   err_total = 0, check_count = 0, cyc = 0;
    logic [5:0][7:0]      codes = {8'h0b, 8'h08, 8'h03, 8'h02, 8'h01, 8'h00};
    logic [4:0][7:0]      ra = {8'h20, 8'h40, 8'h08, 8'h04, 8'h00};
    rpdg_row_s rows [15] = '{
        '{8'h00,8'h01,8'h00,8'h00,2'h2,16'h0050,16'h0050,8'h00,2'h2,16'h0050,16'h0050},
        '{8'h01,8'h01,8'h00,8'h00,2'h2,16'hffb0,16'h0050,8'h00,2'h0,16'h0000,16'h0000},
        '{8'h01,8'h01,8'h00,8'h00,2'h1,16'h0050,16'h0050,8'h00,2'h0,16'h0000,16'h0000},
        '{8'h02,8'h01,8'h00,8'h00,2'h2,16'h0050,16'h0050,8'h00,2'h0,16'h0000,16'h0000},
        '{8'h02,8'h01,8'h00,8'h00,2'h1,16'h0050,16'hffb0,8'h00,2'h3,16'h0050,16'hffb0},
        '{8'h00,8'h01,8'h00,8'h00,2'h2,16'h0200,16'h0050,8'h00,2'h2,16'h0100,16'h0050},
        '{8'h00,8'h01,8'h00,8'h00,2'h2,16'h0004,16'h0050,8'h00,2'h2,16'h0010,16'h0050},
        '{8'h00,8'h01,8'h00,8'h65,2'h2,16'h0050,16'h0050,8'h00,2'h0,16'h0000,16'h0000},
        '{8'h00,8'h01,8'h00,8'h65,2'h2,16'h0050,16'h0050,8'h04,2'h2,16'h0050,16'h0050},
        '{8'h00,8'h01,8'h08,8'h00,2'h2,16'h0050,16'hffb0,8'h00,2'h2,16'h0050,16'h0000},
        '{8'h00,8'h00,8'h08,8'h00,2'h2,16'h0050,16'hffb0,8'h00,2'h2,16'h0050,16'hffb0},
        '{8'h00,8'h01,8'h0b,8'h00,2'h2,16'h0050,16'hffb0,8'h00,2'h2,16'h0050,16'hffb0},
        '{8'h00,8'h01,8'h08,8'h00,2'h2,16'hffb0,16'hffb0,8'h00,2'h3,16'h0050,16'hffb0},
        '{8'h00,8'h01,8'h00,8'h00,2'h3,16'h0050,16'h0050,8'h00,2'h0,16'h0000,16'h0000},
        '{8'h01,8'h01,8'h00,8'h00,2'h2,16'h0050,16'hffb0,8'h00,2'h2,16'h0050,16'hffb0}};

    rpdg_cmd_src u_src (.core_clk(core_clk), .rst(rst), .want_run(wr), .want_freq(wq),
        .want_ctl(wc), .want_term(wt), .run_fwd(run_fwd), .run_rev(run_rev),
        .freq_cmd(freq_cmd), .ctl_freq(ctl_freq), .term_in(term_in));
    rpdg_gate uut (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .run_fwd(run_fwd), .run_rev(run_rev), .freq_cmd(freq_cmd), .term_in(term_in),
        .ctl_freq(ctl_freq), .run_active(run_active), .run_dir_rev(run_dir_rev),
        .freq_ref(freq_ref), .out_freq(out_freq), .ctrl_mode(ctrl_mode), .irq(irq));

    // ----
    // Tasks
    // ----
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        q = hrdata;
        #1;
    endtask
    task automatic cmd(input logic [1:0] c, input logic [15:0] f, x, input logic [7:0] t);
        wr <= c; wq <= f; wc <= x; wt <= t;
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    task automatic rst_seq;
        rst <= 1'b1;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // Hang guard well above the expected run length
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            summarize();
        end
    end

    initial begin
        rst_seq();
        bus(1'b1, 8'h0c, 32'h100);
        bus(1'b1, 8'h10, 32'h10);
        foreach (rows[i]) begin
            bus(1'b1, 8'h00, {24'h0, rows[i].d});
            bus(1'b1, 8'h04, {24'h0, rows[i].g});
            bus(1'b1, 8'h08, {24'h0, rows[i].m});
            bus(1'b1, 8'h28, {24'h0, rows[i].f}); // Zero unassigns
            cmd(rows[i].c, rows[i].fq, rows[i].cf, rows[i].tm);
            `CHK({run_active, run_dir_rev}, rows[i].e)
            `CHK(freq_ref, rows[i].ef)
            `CHK(out_freq, rows[i].eo)
            $display("row %0d done", i);
        end
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, 8'h08, {24'h0, codes[i]});
            `CHK(ctrl_mode, rpdg_pkg::rpdg_mode_e'(i))
        end
        bus(1'b1, 8'h08, 32'h5);
        `CHK(ctrl_mode, rpdg_pkg::RPDG_MODE_VF_CT)
        $display("modes done");
        rst_seq();
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, ra[i], 32'h0);
            `CHK(q, {31'h0, ra[i] == 8'h04})
        end
        $display("reset values done");
        bus(1'b1, 8'h1c, 32'h1);
        bus(1'b1, 8'h00, 32'h1);
        cmd(2'h1, 16'h0050, 16'h0, 8'h00);
        `CHK(irq, 1'b1)
        bus(1'b1, 8'h18, 32'h1);
        `CHK(irq, 1'b0)
        bus(1'b1, 8'h1c, 32'h0);
        cmd(2'h0, 16'h0050, 16'h0, 8'h00);
        cmd(2'h1, 16'h0050, 16'h0, 8'h00);
        `CHK(irq, 1'b0)
        bus(1'b0, 8'h18, 32'h0);
        `CHK(q[0], 1'b1)
        bus(1'b1, 8'h1c, 32'h1);
        `CHK(irq, 1'b1)
        $display("irq done");
        summarize();
    end
endmodule
